// file: include/ucf_pkg.sv
package ucf_pkg;
   // register byte addresses
   localparam logic [3:0] ADR_CTRL = 4'h0;
   localparam logic [3:0] ADR_DIV_LO = 4'h4;
   localparam logic [3:0] ADR_DIV_HI = 4'h8;
   localparam logic [3:0] ADR_DATA = 4'hC;
   // control field positions
   localparam int CTRL_DSPEED = 0;
   localparam int CTRL_SYNC = 1;
   localparam int CTRL_XDIR = 2;
   localparam int CTRL_CPOL = 3;
   localparam int CTRL_STOP2 = 4;
   localparam int CTRL_PAR_LO = 5;
   localparam int CTRL_CSZ_LO = 7;
   localparam int CTRL_TXEN = 10;
   localparam int CTRL_RXEN = 11;
   localparam logic [11:0] CTRL_RST = 12'h006;
   // status bits in the data word
   localparam int ST_RXVALID = 9;
   localparam int ST_TXEMPTY = 10;
   localparam int ST_FERR = 11;
   localparam int ST_PERR = 12;
   localparam int ST_OVR = 13;
   // parity and size codes
   localparam logic [1:0] PAR_EVEN = 2'h2;
   localparam logic [1:0] PAR_ODD = 2'h3;
   localparam logic [2:0] CSZ_9 = 3'h7;
   // oversampling ratios
   localparam logic [3:0] OVS_NORM = 4'hF;
   localparam logic [3:0] OVS_DBL = 4'h7;
   localparam logic [3:0] OVS_SYNC = 4'h1;
   localparam int DIV_W = 12;
endpackage

// file: rtl/ucf_baud.sv
`timescale 1ns/1ps
module ucf_baud
   import ucf_pkg::*;
#(
   parameter int W = DIV_W
) (
   // clock and reset
   input wire logic i_clk,
   input wire logic i_rstn,
   // divisor control
   input wire logic [W-1:0] i_div,
   input wire logic i_reload,
   // tick out
   output logic o_tick
);
   typedef struct packed {
      logic [W-1:0] cnt;
      logic tick;
   } ucf_baud_t;
   ucf_baud_t s_r, s_nxt;

   always_comb begin
      s_nxt = s_r;
      s_nxt.tick = 1'b0;
      if (i_reload) begin
         s_nxt.cnt = i_div;
      end else if (s_r.cnt == '0) begin
         s_nxt.cnt = i_div;
         s_nxt.tick = 1'b1;
      end else begin
         s_nxt.cnt = s_r.cnt - 1'b1;
      end
   end

   always_ff @(posedge i_clk or negedge i_rstn) begin
      if (!i_rstn) begin
         s_r <= '0;
      end else begin
         s_r <= s_nxt;
      end
   end
   assign o_tick = s_r.tick;

   chk_tick_rate: assert property (@(posedge i_clk) disable iff (!i_rstn)
      (o_tick && i_div == '0 && !i_reload) |=> (i_reload || o_tick)) else $error("baud tick rate wrong");
   chk_reload_low: assert property (@(posedge i_clk) disable iff (!i_rstn)
      i_reload |=> (s_r.cnt == $past(i_div) && !o_tick)) else $error("reload not taken");
endmodule

// file: rtl/ucf_xck_sync.sv
`timescale 1ns/1ps
module ucf_xck_sync (
   // clock and reset
   input wire logic i_clk,
   input wire logic i_rstn,
   // pin level
   input wire logic i_pin,
   // edge pulses and synced level
   output logic o_rise,
   output logic o_fall,
   output logic o_level
);
   typedef struct packed {
      logic s1;
      logic s2;
      logic s3;
   } ucf_xsync_t;
   ucf_xsync_t s_r, s_nxt;

   always_comb begin
      s_nxt.s1 = i_pin;
      s_nxt.s2 = s_r.s1;
      s_nxt.s3 = s_r.s2;
   end

   always_ff @(posedge i_clk or negedge i_rstn) begin
      if (!i_rstn) begin
         s_r <= '0;
      end else begin
         s_r <= s_nxt;
      end
   end
   // edge detector reads only the second stage onward
   assign o_rise = s_r.s2 & ~s_r.s3;
   assign o_fall = ~s_r.s2 & s_r.s3;
   assign o_level = s_r.s2;

   chk_edge_delay: assert property (@(posedge i_clk) disable iff (!i_rstn)
      ($rose(i_pin) ##1 i_pin ##1 i_pin) |-> o_rise || $past(o_rise)) else $error("edge delay wrong");
endmodule

// file: rtl/ucf_usart.sv
// Design decisions made here: the Wishbone slave port and the address map.
`timescale 1ns/1ps
module ucf_usart
   import ucf_pkg::*;
(
   // system
   input wire logic I_CLK,
   input wire logic I_RSTN,
   // wishbone slave
   input wire logic I_WB_CYC,
   input wire logic I_WB_STB,
   input wire logic I_WB_WE,
   input wire logic [3:0] I_WB_ADR,
   input wire logic [3:0] I_WB_SEL,
   input wire logic [31:0] I_WB_DAT,
   output logic [31:0] O_WB_DAT,
   output logic O_WB_ACK,
   // serial pins
   input wire logic I_SERIAL_IN_PIN,
   output logic O_SERIAL_OUT_PIN,
   // transfer clock pin, oe low drives
   input wire logic I_XFER_CLK,
   output logic O_XFER_CLK,
   output logic O_XFER_CLK_OE_N
);
   typedef enum logic [1:0] {TX_IDLE, TX_SHIFT} ucf_txst_t;
   typedef enum logic [1:0] {RX_IDLE, RX_START, RX_BITS} ucf_rxst_t;
   typedef struct packed {
      logic [11:0] ctrl;
      logic [DIV_W-1:0] div;
      logic ack;
      logic [31:0] rdat;
      // transmitter
      logic [8:0] tbuf;
      logic tbuf_full;
      ucf_txst_t tst;
      logic [11:0] tsh;
      logic [3:0] tbits;
      logic [3:0] tdiv;
      logic tout;
      logic xck;
      // receiver
      ucf_rxst_t rst;
      logic [3:0] rph;
      logic [3:0] rbits;
      logic [11:0] rsh;
      logic [8:0] rq0, rq1;
      logic [1:0] rq0_err, rq1_err;
      logic [1:0] rcnt;
      logic ovr;
   } ucf_st_t;
   ucf_st_t s_r, s_nxt;

   logic tick, x_rise, x_fall, rx_s1, rx_s2;
   logic sync_m, dspd, slave, master;
   logic [3:0] nbits, ovs;
   logic wr, rd, tx_edge, rx_edge, parity, sbit;
   logic [8:0] dmask, rdata;

   // ---------------------------------------------------------------
   // clocking
   // ---------------------------------------------------------------
   assign sync_m = s_r.ctrl[CTRL_SYNC];
   assign dspd = s_r.ctrl[CTRL_DSPEED] & ~sync_m;
   assign master = sync_m & s_r.ctrl[CTRL_XDIR];
   assign slave = sync_m & ~s_r.ctrl[CTRL_XDIR];
   assign ovs = sync_m ? OVS_SYNC : (dspd ? OVS_DBL : OVS_NORM);
   assign wr = I_WB_CYC & I_WB_STB & I_WB_WE & ~s_r.ack;
   assign rd = I_WB_CYC & I_WB_STB & ~I_WB_WE & ~s_r.ack;

   ucf_baud #(.W(DIV_W)) u_baud (
      .i_clk(I_CLK),
      .i_rstn(I_RSTN),
      // next divisor, so a low byte write reloads with the new value
      .i_div(s_nxt.div),
      .i_reload(wr && I_WB_ADR == ADR_DIV_LO && I_WB_SEL[0]),
      .o_tick(tick)
   );

   ucf_xck_sync u_xck (
      .i_clk(I_CLK),
      .i_rstn(I_RSTN),
      .i_pin(I_XFER_CLK),
      .o_rise(x_rise),
      .o_fall(x_fall),
      .o_level()
   );

   // serial input synchroniser
   always_ff @(posedge I_CLK or negedge I_RSTN) begin
      if (!I_RSTN) begin
         rx_s1 <= 1'b1;
         rx_s2 <= 1'b1;
      end else begin
         rx_s1 <= I_SERIAL_IN_PIN;
         rx_s2 <= rx_s1;
      end
   end

   // ---------------------------------------------------------------
   // frame format helpers
   // ---------------------------------------------------------------
   assign nbits = (s_r.ctrl[CTRL_CSZ_LO+:3] == CSZ_9) ? 4'h9
                  : 4'h5 + {2'b00, s_r.ctrl[CTRL_CSZ_LO+:2]};
   always_comb begin
      for (int i = 0; i < 9; i++) begin
         dmask[i] = (i < nbits);
      end
   end
   assign parity = ^(s_r.tbuf & dmask) ^ s_r.ctrl[CTRL_PAR_LO];
   assign sbit = s_r.ctrl[CTRL_PAR_LO+1];
   // frame word as it stands after the first stop bit is shifted in
   assign rdata = 9'({rx_s2, s_r.rsh[11:1]} >> (4'hB - nbits - {3'b000, sbit})) & dmask;

   // sync edge choice: polarity 0 changes on rise, samples on fall
   always_comb begin
      if (slave) begin
         tx_edge = s_r.ctrl[CTRL_CPOL] ? x_fall : x_rise;
         rx_edge = s_r.ctrl[CTRL_CPOL] ? x_rise : x_fall;
      end else if (master) begin
         tx_edge = tick & (s_r.xck == s_r.ctrl[CTRL_CPOL]);
         rx_edge = tick & (s_r.xck != s_r.ctrl[CTRL_CPOL]);
      end else begin
         tx_edge = tick & (s_r.tdiv == '0);
         rx_edge = tick;
      end
   end

   // ---------------------------------------------------------------
   // main next state
   // ---------------------------------------------------------------
   always_comb begin
      s_nxt = s_r;
      s_nxt.ack = I_WB_CYC & I_WB_STB & ~s_r.ack;
      // register writes
      if (wr) begin
         case (I_WB_ADR)
            ADR_CTRL: begin
               if (I_WB_SEL[0]) s_nxt.ctrl[7:0] = I_WB_DAT[7:0];
               if (I_WB_SEL[1]) s_nxt.ctrl[11:8] = I_WB_DAT[11:8];
            end
            ADR_DIV_LO: begin
               if (I_WB_SEL[0]) s_nxt.div[7:0] = I_WB_DAT[7:0];
            end
            ADR_DIV_HI: begin
               if (I_WB_SEL[0]) s_nxt.div[11:8] = I_WB_DAT[3:0];
            end
            ADR_DATA: begin
               if (I_WB_SEL[0] && !s_r.tbuf_full) begin
                  s_nxt.tbuf = I_WB_DAT[8:0] & dmask;
                  s_nxt.tbuf_full = 1'b1;
               end
            end
            default: begin
            end
         endcase
      end
      // register reads; a data read pops the receive buffer
      case (I_WB_ADR)
         ADR_CTRL: s_nxt.rdat = {20'h0, s_r.ctrl};
         ADR_DIV_LO: s_nxt.rdat = {24'h0, s_r.div[7:0]};
         ADR_DIV_HI: s_nxt.rdat = {28'h0, s_r.div[11:8]};
         ADR_DATA: s_nxt.rdat = {18'h0, s_r.ovr, s_r.rq0_err, ~s_r.tbuf_full,
                                 s_r.rcnt != 2'h0, s_r.rq0};
         default: s_nxt.rdat = 32'h0;
      endcase
      if (rd && I_WB_ADR == ADR_DATA && s_r.rcnt != 2'h0) begin
         s_nxt.rq0 = s_r.rq1;
         s_nxt.rq0_err = s_r.rq1_err;
         s_nxt.rcnt = s_r.rcnt - 2'h1;
         s_nxt.ovr = 1'b0;
      end

      // sync master clock pin output
      if (master && tick) begin
         s_nxt.xck = ~s_r.xck;
      end else if (!master) begin
         s_nxt.xck = s_r.ctrl[CTRL_CPOL];
      end

      // transmitter
      if (!sync_m && tick) begin
         s_nxt.tdiv = (s_r.tdiv == '0) ? ovs : s_r.tdiv - 1'b1;
      end
      case (s_r.tst)
         TX_IDLE: begin
            s_nxt.tout = 1'b1;
            if (s_r.tbuf_full && s_r.ctrl[CTRL_TXEN] && tx_edge) begin
               // lsb-first shift: data, parity, stops; the start bit goes straight to the pin
               s_nxt.tsh = ({3'b111, s_r.tbuf} | ~{3'b000, dmask});
               if (sbit) s_nxt.tsh[nbits] = parity;
               // first stop is shifted too, so a follow-on start never eats it
               s_nxt.tbits = nbits + {3'b000, sbit} + {3'b000, s_r.ctrl[CTRL_STOP2]} + 4'h1;
               s_nxt.tout = 1'b0;
               s_nxt.tbuf_full = 1'b0;
               s_nxt.tst = TX_SHIFT;
            end
         end
         TX_SHIFT: begin
            if (tx_edge) begin
               if (s_r.tbits == '0) begin
                  s_nxt.tst = TX_IDLE;
                  s_nxt.tout = 1'b1;
                  // back-to-back frame from the write buffer
                  if (s_r.tbuf_full && s_r.ctrl[CTRL_TXEN]) begin
                     s_nxt.tsh = ({3'b111, s_r.tbuf} | ~{3'b000, dmask});
                     if (sbit) s_nxt.tsh[nbits] = parity;
                     s_nxt.tbits = nbits + {3'b000, sbit} + {3'b000, s_r.ctrl[CTRL_STOP2]} + 4'h1;
                     s_nxt.tout = 1'b0;
                     s_nxt.tbuf_full = 1'b0;
                     s_nxt.tst = TX_SHIFT;
                  end
               end else begin
                  s_nxt.tout = s_r.tsh[0];
                  s_nxt.tsh = {1'b1, s_r.tsh[11:1]};
                  s_nxt.tbits = s_r.tbits - 1'b1;
               end
            end
         end
         default: s_nxt.tst = TX_IDLE;
      endcase

      // receiver: async oversamples the tick, sync uses rx_edge only
      case (s_r.rst)
         RX_IDLE: begin
            s_nxt.rph = '0;
            if (s_r.ctrl[CTRL_RXEN] && rx_edge && !rx_s2) begin
               s_nxt.rst = sync_m ? RX_BITS : RX_START;
               s_nxt.rbits = nbits + {3'b000, sbit} + 4'h1;
               s_nxt.rph = sync_m ? 4'h0 : 4'h1;
            end
         end
         RX_START: begin
            if (rx_edge) begin
               s_nxt.rph = s_r.rph + 1'b1;
               if (s_r.rph == {1'b0, ovs[3:1]}) begin
                  // mid start bit: false start returns to idle
                  s_nxt.rst = rx_s2 ? RX_IDLE : RX_BITS;
                  s_nxt.rph = '0;
               end
            end
         end
         RX_BITS: begin
            if (rx_edge) begin
               s_nxt.rph = (s_r.rph == ovs || sync_m) ? 4'h0 : s_r.rph + 1'b1;
               if (s_r.rph == ovs || sync_m) begin
                  s_nxt.rsh = {rx_s2, s_r.rsh[11:1]};
                  s_nxt.rbits = s_r.rbits - 1'b1;
                  if (s_r.rbits == 4'h1) begin
                     // first stop bit only; a second is ignored
                     s_nxt.rst = RX_IDLE;
                     if (s_r.rcnt == 2'h2) begin
                        s_nxt.ovr = 1'b1;
                     end
                  end
               end
            end
         end
         default: s_nxt.rst = RX_IDLE;
      endcase
      if (s_r.rst == RX_BITS && s_nxt.rst == RX_IDLE && s_r.rcnt != 2'h2) begin
         if (s_nxt.rcnt == 2'h0 || (s_nxt.rcnt == 2'h1 && s_r.rcnt == 2'h2)) begin
            s_nxt.rq0 = rdata;
            s_nxt.rq0_err = {(^rdata ^ s_r.rsh[11] ^ s_r.ctrl[CTRL_PAR_LO]) & sbit, ~rx_s2};
         end else begin
            s_nxt.rq1 = rdata;
            s_nxt.rq1_err = {1'b0, ~rx_s2};
         end
         s_nxt.rcnt = s_nxt.rcnt + 2'h1;
      end
   end

   always_ff @(posedge I_CLK or negedge I_RSTN) begin
      if (!I_RSTN) begin
         s_r <= '0;
         s_r.ctrl <= CTRL_RST;
         s_r.tout <= 1'b1;
         s_r.tst <= TX_IDLE;
         s_r.rst <= RX_IDLE;
      end else begin
         s_r <= s_nxt;
      end
   end

   // ---------------------------------------------------------------
   // outputs
   // ---------------------------------------------------------------
   assign O_WB_ACK = s_r.ack;
   assign O_WB_DAT = s_r.rdat;
   assign O_SERIAL_OUT_PIN = s_r.tout;
   assign O_XFER_CLK = s_r.xck;
   assign O_XFER_CLK_OE_N = ~master;

   chk_start_low: assert property (@(posedge I_CLK) disable iff (!I_RSTN)
      (s_r.tst == TX_IDLE && s_nxt.tst == TX_SHIFT) |=> !O_SERIAL_OUT_PIN) else $error("start not low");
   chk_idle_high: assert property (@(posedge I_CLK) disable iff (!I_RSTN)
      (s_r.tst == TX_IDLE && !s_r.tbuf_full) |=> O_SERIAL_OUT_PIN) else $error("idle not high");
   chk_pin_unused: assert property (@(posedge I_CLK) disable iff (!I_RSTN)
      !sync_m |-> O_XFER_CLK_OE_N) else $error("clock pin driven in async");
   chk_ack_one: assert property (@(posedge I_CLK) disable iff (!I_RSTN)
      O_WB_ACK |=> !O_WB_ACK) else $error("ack held");
   chk_dspd_sync: assert property (@(posedge I_CLK) disable iff (!I_RSTN)
      sync_m |-> ovs == OVS_SYNC) else $error("double speed leaks into sync");
   chk_ovs_dbl: assert property (@(posedge I_CLK) disable iff (!I_RSTN)
      (!sync_m && s_r.ctrl[CTRL_DSPEED]) |-> ovs == OVS_DBL) else $error("double speed ratio");
   chk_master_edge: assert property (@(posedge I_CLK) disable iff (!I_RSTN)
      (master && tick) |=> O_XFER_CLK != $past(O_XFER_CLK)) else $error("master clock");
   chk_rx_depth: assert property (@(posedge I_CLK) disable iff (!I_RSTN)
      s_r.rcnt <= 2'h2) else $error("rx buffer depth");
   cov_tx_frame: cover property (@(posedge I_CLK) disable iff (!I_RSTN) s_r.tst == TX_SHIFT);
   cov_rx_frame: cover property (@(posedge I_CLK) disable iff (!I_RSTN) s_r.rcnt == 2'h2);
   cov_slave: cover property (@(posedge I_CLK) disable iff (!I_RSTN) slave && x_rise);
endmodule

// file: verification/ucf_remote.sv
`timescale 1ns/1ps
// ----------------------------------------
// remote serial transceiver
// ----------------------------------------
module ucf_remote (
   // serial lines
   input wire logic i_line,
   input wire logic i_xck,
   output logic o_line
);
   realtime t_start;
   realtime t_per;
   initial o_line = 1'b1;
   // mid-bit sampling; no wait after the last bit so a gap-free next start is caught
   task automatic get_async(input int bt, input int n, output logic [12:0] f);
      f = '1;
      @(negedge i_line);
      t_start = $realtime;
      #(bt / 2);
      for (int i = 0; i < n; i++) begin
         f[i] = i_line;
         if (i < n - 1)
            #(bt);
      end
   endtask
   // start low, data lsb first, stops high
   task automatic put_async(input int bt, input int n, input logic [12:0] f);
      #1;
      for (int i = 0; i < n; i++) begin
         o_line = f[i];
         #(bt);
      end
      o_line = 1'b1;
   endtask
   // sample on the edge opposite to the change edge
   task automatic get_sync(input logic pol, input int n, output logic [12:0] f);
      realtime t0;
      int i;
      f = '1;
      i = 0;
      t0 = 0;
      while (i < n) begin
         if (pol)
            @(posedge i_xck);
         else
            @(negedge i_xck);
         t_per = $realtime - t0;
         t0 = $realtime;
         if (i > 0 || i_line == 1'b0) begin
            f[i] = i_line;
            i++;
         end
      end
   endtask
endmodule

// file: verification/test_ucf_usart.sv
`timescale 1ns/1ps
module test_ucf_usart;
   import ucf_pkg::*;
   logic clk, rstn, cyc, stb, we, ack, sout, sin, xo, xoe_n, xin;
   logic [3:0] adr, sel;
   logic [31:0] wdat, rdat;
   int n_fail = 0;
   int check_count = 0;
   int cycles = 0;
   // ----------------------------------------
   // harness
   // ----------------------------------------
   ucf_usart i_dut (.I_CLK(clk), .I_RSTN(rstn), .I_WB_CYC(cyc), .I_WB_STB(stb), .I_WB_WE(we),
      .I_WB_ADR(adr), .I_WB_SEL(sel), .I_WB_DAT(wdat), .O_WB_DAT(rdat), .O_WB_ACK(ack),
      .I_SERIAL_IN_PIN(sin), .O_SERIAL_OUT_PIN(sout),
      .I_XFER_CLK(xin),
      .O_XFER_CLK(xo), .O_XFER_CLK_OE_N(xoe_n));
   ucf_remote i_remote (.i_line(sout), .i_xck(xoe_n ? xin : xo), .o_line(sin));
   initial begin
      clk = 1'b0;
      forever #25 clk = ~clk;
   end
   always @(posedge clk) begin
      cycles <= cycles + 1;
      if (cycles == 60000) begin
         n_fail++;
         give_verdict();
      end
   end
   task automatic give_verdict();
      $display("checks %0d mismatches %0d", check_count, n_fail);
      if (n_fail == 0 && check_count > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      check_count++;
      if (seen !== exp) begin
         n_fail++;
         $display("Error at %0t: saw %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic wb(input logic w, input logic [3:0] a, input logic [31:0] d, output logic [31:0] q);
      int n;
      n = 0;
      @(posedge clk);
      cyc <= 1'b1;
      stb <= 1'b1;
      we <= w;
      adr <= a;
      wdat <= d;
      do begin
         @(posedge clk);
         n++;
      end while (ack !== 1'b1 && n < 40);
      q = rdat;
      if (n >= 40)
         chk(32'h0, 32'h1);
      cyc <= 1'b0;
      stb <= 1'b0;
   endtask
   task automatic wr(input logic [3:0] a, input logic [31:0] d);
      logic [31:0] q;
      wb(1'b1, a, d, q);
   endtask
   function automatic logic [31:0] cw(input int nd, input logic [1:0] pm, input logic s2, input logic dsp,
      input logic sy, input logic pol);
      logic [2:0] cs;
      cs = (nd == 9) ? CSZ_9 : 3'(nd - 5);
      return (32'(cs) << CTRL_CSZ_LO) | (32'(pm) << CTRL_PAR_LO) | (32'(s2) << CTRL_STOP2)
         | (32'(pol) << CTRL_CPOL) | (32'(sy) << CTRL_XDIR) | (32'(sy) << CTRL_SYNC)
         | (32'(dsp) << CTRL_DSPEED) | (32'h3 << CTRL_TXEN);
   endfunction
   function automatic logic [12:0] mkf(input logic [8:0] d, input int nd, input logic [1:0] pm,
      input logic s2, output int n);
      logic [12:0] f;
      logic p;
      f = '1;
      f[0] = 1'b0;
      p = (pm == PAR_ODD);
      for (int i = 0; i < nd; i++) begin
         f[i + 1] = d[i];
         p ^= d[i];
      end
      if (pm[1])
         f[nd + 1] = p;
      n = nd + 2 + int'(pm[1]) + int'(s2);
      return f;
   endfunction
   task automatic setup(input logic [31:0] c, input int dv);
      wr(ADR_DIV_HI, 32'h0);
      wr(ADR_DIV_LO, 32'(dv));
      wr(ADR_CTRL, c);
   endtask
   // ----------------------------------------
   // scenarios
   // ----------------------------------------
   task automatic t_regs();
      logic [31:0] q;
      wb(1'b0, ADR_CTRL, 32'h0, q);
      chk(q & 32'hFFF, 32'(CTRL_RST));
      wb(1'b0, 4'h1, 32'h0, q);
      chk(q, 32'h0);
      wb(1'b0, ADR_DATA, 32'h0, q);
      chk(32'(q[ST_TXEMPTY]), 32'h1);
      $display("registers done");
   endtask
   // two writes back to back must leave the line as two gap-free frames
   task automatic t_tx(input int nd, input logic [1:0] pm, input logic s2, input logic dsp, input int dv,
      input logic [8:0] d0, input logic [8:0] d1);
      int n, bt;
      logic [12:0] f, g;
      logic [31:0] q;
      realtime t1;
      bt = (dsp ? 8 : 16) * (dv + 1) * 50;
      setup(cw(nd, pm, s2, dsp, 1'b0, 1'b0), dv);
      f = mkf(d0, nd, pm, s2, n);
      fork
         begin
            i_remote.get_async(bt, n, f);
            t1 = i_remote.t_start;
            i_remote.get_async(bt, n, g);
         end
         begin
            wr(ADR_DATA, 32'(d0));
            // a write into a full buffer is dropped, so wait for it to drain
            do
               wb(1'b0, ADR_DATA, 32'h0, q);
            while (q[ST_TXEMPTY] !== 1'b1);
            wr(ADR_DATA, 32'(d1));
         end
      join
      chk(32'(f), 32'(mkf(d0, nd, pm, s2, n)));
      chk(32'(g), 32'(mkf(d1, nd, pm, s2, n)));
      chk(32'(int'(i_remote.t_start - t1)), 32'(n * bt));
      chk(32'(xoe_n), 32'h1);
      $display("transmit %0d bits done", nd);
   endtask
   // bad: 1 first stop low, 2 parity flipped
   task automatic t_rx(input int nd, input logic [1:0] pm, input logic s2, input logic dsp, input int dv,
      input logic [8:0] d, input int bad);
      int n, bt;
      logic [12:0] f;
      logic [31:0] q;
      bt = (dsp ? 8 : 16) * (dv + 1) * 50;
      setup(cw(nd, pm, s2, dsp, 1'b0, 1'b0), dv);
      f = mkf(d, nd, pm, s2, n);
      if (bad == 1)
         f[n - 1 - int'(s2)] = 1'b0;
      if (bad == 2)
         f[nd + 1] = ~f[nd + 1];
      i_remote.put_async(bt, n, f);
      repeat (4) @(posedge clk);
      wb(1'b0, ADR_DATA, 32'h0, q);
      chk(32'(q[8:0]), 32'(d & 9'((1 << nd) - 1)));
      chk(32'(q[ST_RXVALID]), 32'h1);
      chk(32'(q[ST_FERR]), 32'(bad == 1));
      chk(32'(q[ST_PERR]), 32'(bad == 2));
      wb(1'b0, ADR_DATA, 32'h0, q);
      chk(32'(q[ST_RXVALID]), 32'h0);
      $display("receive %0d bits done", nd);
   endtask
   task automatic t_sync(input logic pol);
      int n;
      logic [12:0] f;
      setup(cw(8, PAR_EVEN, 1'b0, 1'b0, 1'b1, pol), 3);
      f = mkf(9'h0B6, 8, PAR_EVEN, 1'b0, n);
      fork
         i_remote.get_sync(pol, n, f);
         wr(ADR_DATA, 32'h0B6);
      join
      chk(32'(f), 32'(mkf(9'h0B6, 8, PAR_EVEN, 1'b0, n)));
      chk(32'(int'(i_remote.t_per)), 32'd400);
      chk(32'(xoe_n), 32'h0);
      setup(cw(8, PAR_EVEN, 1'b0, 1'b0, 1'b0, 1'b0), 1);
      chk(32'(xoe_n), 32'h1);
      $display("sync polarity %0d done", pol);
   endtask
   // slave: remote supplies the transfer clock, well under a quarter of the system clock
   task automatic t_slave();
      int n;
      logic [12:0] f;
      bit run;
      setup(cw(7, PAR_ODD, 1'b1, 1'b0, 1'b1, 1'b0) & ~(32'h1 << CTRL_XDIR), 3);
      f = mkf(9'h05C, 7, PAR_ODD, 1'b1, n);
      run = 1'b1;
      fork
         begin
            i_remote.get_sync(1'b0, n, f);
            run = 1'b0;
         end
         wr(ADR_DATA, 32'h05C);
         while (run) begin
            repeat (5) @(posedge clk);
            xin <= ~xin;
         end
      join
      chk(32'(f), 32'(mkf(9'h05C, 7, PAR_ODD, 1'b1, n)));
      chk(32'(xoe_n), 32'h1);
      $display("sync slave done");
   endtask
   initial begin
      cyc = 1'b0;
      stb = 1'b0;
      we = 1'b0;
      adr = 4'h0;
      sel = 4'hF;
      wdat = 32'h0;
      xin = 1'b0;
      rstn = 1'b0;
      repeat (6) @(posedge clk);
      rstn <= 1'b1;
      t_regs();
      t_tx(8, PAR_EVEN, 1'b1, 1'b0, 2, 9'h0A5, 9'h03C);
      t_tx(5, PAR_ODD, 1'b0, 1'b1, 1, 9'h016, 9'h009);
      t_tx(9, 2'h0, 1'b0, 1'b0, 1, 9'h1C3, 9'h155);
      t_tx(7, PAR_ODD, 1'b1, 1'b1, 0, 9'h04E, 9'h031);
      t_tx(6, PAR_EVEN, 1'b0, 1'b0, 0, 9'h02B, 9'h014);
      t_rx(8, PAR_EVEN, 1'b1, 1'b0, 2, 9'h0A5, 0);
      t_rx(6, PAR_ODD, 1'b0, 1'b1, 1, 9'h02D, 0);
      t_rx(9, 2'h0, 1'b0, 1'b0, 1, 9'h1A6, 0);
      t_rx(8, PAR_EVEN, 1'b1, 1'b0, 1, 9'h05A, 1);
      t_rx(7, PAR_ODD, 1'b0, 1'b1, 1, 9'h033, 2);
      t_sync(1'b0);
      t_sync(1'b1);
      t_slave();
      give_verdict();
   end
endmodule
